/* include/tma_pkg.sv */
// Purpose: shared constants and carriers for the timer mode / compare-a status block
// Assumes: 8-bit mode and status registers, 4-bit event and mask registers, on a 32-bit APB, one word per register
// Notes: offsets are byte addresses
package tma_pkg;
    localparam int unsigned TMA_NCH = 3;
    localparam logic [7:0] TMA_OFF_MODE = 8'h00;
    localparam logic [7:0] TMA_OFF_STAT = 8'h04;
    localparam logic [7:0] TMA_OFF_EVT = 8'h08;
    localparam logic [7:0] TMA_OFF_MASK = 8'h0c;
    localparam logic [7:0] TMA_MODE_RESET = 8'h98;
    localparam logic [7:0] TMA_MODE_RSV = 8'h98;
    localparam logic [7:0] TMA_STAT_RESET = 8'h88;
    localparam logic [7:0] TMA_STAT_RSV = 8'h88;
    localparam int unsigned TMA_BIT_PHASE = 6;
    localparam int unsigned TMA_BIT_OVERFLOW_DIRECTION_SELECT = 5;
    localparam int unsigned TMA_LSB_PWM = 0;
    localparam int unsigned TMA_LSB_IEN = 4;
    localparam int unsigned TMA_LSB_FLAG = 0;
    localparam int unsigned TMA_NEVT = 4;
    localparam int unsigned TMA_EVT_OVF = 3;
    localparam logic [3:0] TMA_EVT_ZERO = 4'h0;
    localparam logic [31:0] TMA_WORD_ZERO = 32'h0000_0000;
    // per-channel events from the counter and capture logic
    typedef struct packed {
        logic [2:0] match_a;
        logic [2:0] match_b;
        logic [2:0] capture_a;
        logic [2:0] a_is_capture;
    } tma_chan_evt_t;
    // channel 2 counting controls
    typedef struct packed {
        logic count_en;
        logic count_up;
        logic ovf_set;
    } tma_ch2_cnt_t;
endpackage : tma_pkg

/* src/tma_core.sv */
// Purpose: timer mode register, compare-a status register, pwm pins, channel 2 phase counting
// Assumes: all inputs synchronous to pclk; counters and compare registers live outside
// Notes: zero-wait APB slave; event status and mask registers drive one interrupt line
//
// What this block does
// - mode register loads 0x98 at reset and during standby
// - mode bits 7, 4, 3 read as one and ignore writes
// - phase mode bit set makes channel 2 count up/down from quadrature pins
// - count both edges of both pins; direction from the other pin's level
// - in phase mode the normal channel 2 clock tick is ignored
// - clear, compare, capture and flags keep working in phase mode
// - overflow direction bit: zero flags overflow and underflow, one overflow only
// - mode bits 2..0 select pwm mode for channels 2..0
// - pwm pin goes high on compare-a match, low on compare-b match
// - compare-a status register loads 0x88 at reset and during standby
// - status bits 7 and 3 read as one and ignore writes
// - channel interrupt request is flag and its enable
// - flag sets on counter equal compare-a in output compare use
// - flag sets on input capture into compare-a in capture use
// - flag clears by reading one then writing zero; writing one does nothing
`timescale 1ns/1ns
module tma_core
    import tma_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic standby,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tma_pkg::tma_chan_evt_t chan_evt,
    input wire logic ch2_clock_tick,
    input wire logic ch2_overflow,
    input wire logic ch2_underflow,
    input wire logic quadrature_in_a,
    input wire logic quadrature_in_b,
    output tma_pkg::tma_ch2_cnt_t ch2_cnt,
    output logic [2:0] compare_a_pin,
    output logic [2:0] compare_a_pin_oe,
    output logic [2:0] cmp_a_irq,
    output logic irq
);
    import tma_pkg::*;

    // quadrature direction: up for the four forward transitions
    function automatic logic quad_up(input logic ar, input logic af, input logic br,
                                     input logic bf, input logic a, input logic b);
        quad_up = (ar & b) | (af & ~b) | (br & ~a) | (bf & a);
    endfunction : quad_up

    logic [7:0] timer_mode_reg;
    logic [7:0] compare_a_status_reg;
    logic [3:0] evt_status;
    logic [3:0] evt_mask;
    logic [2:0] clr_armed;
    logic [7:0] next_mode;
    logic [7:0] next_stat;
    logic [3:0] next_evt;
    logic [3:0] next_mask;
    logic [2:0] next_armed;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic phase_count_select;
    logic overflow_direction_select;
    logic [2:0] pulse_mode;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic [3:0] evt_in;

    assign pready = 1'b1;
    assign mapped = (paddr == TMA_OFF_MODE) || (paddr == TMA_OFF_STAT)
                 || (paddr == TMA_OFF_EVT) || (paddr == TMA_OFF_MASK);
    assign pslverr = psel & penable & ~mapped;
    assign wr_acc = psel & penable & pwrite & mapped;
    assign rd_acc = psel & penable & ~pwrite & mapped;
    assign phase_count_select = timer_mode_reg[TMA_BIT_PHASE];
    assign overflow_direction_select = timer_mode_reg[TMA_BIT_OVERFLOW_DIRECTION_SELECT];
    assign pulse_mode = timer_mode_reg[TMA_LSB_PWM +: 3];

    // flag set from compare match or capture depending on register use
    assign flag_set = (chan_evt.match_a & ~chan_evt.a_is_capture)
                    | (chan_evt.capture_a & chan_evt.a_is_capture);
    // clear only for bits read as one and then written zero
    assign flag_clr = (wr_acc && paddr == TMA_OFF_STAT)
                    ? (clr_armed & ~pwdata[TMA_LSB_FLAG +: 3]) : 3'b000;

    // interrupt request per channel
    assign cmp_a_irq = compare_a_status_reg[TMA_LSB_FLAG +: 3]
                     & compare_a_status_reg[TMA_LSB_IEN +: 3];
    assign evt_in = {ch2_cnt.ovf_set, flag_set};
    assign irq = |(evt_status & evt_mask);

    // register next values
    always_comb
    begin
        next_mode = timer_mode_reg;
        next_stat = compare_a_status_reg;
        next_evt = evt_status;
        next_mask = evt_mask;
        next_armed = clr_armed;
        if (wr_acc && paddr == TMA_OFF_MODE)
        begin
            next_mode = (pwdata[7:0] & ~TMA_MODE_RSV) | TMA_MODE_RSV;
        end
        if (wr_acc && paddr == TMA_OFF_STAT)
        begin
            next_stat[TMA_LSB_IEN +: 3] = pwdata[TMA_LSB_IEN +: 3];
            next_armed = 3'b000;
        end
        if (rd_acc && paddr == TMA_OFF_STAT)
        begin
            // arm only the bits this read returned as one
            next_armed = prdata[TMA_LSB_FLAG +: 3];
        end
        if (wr_acc && paddr == TMA_OFF_MASK)
        begin
            next_mask = pwdata[TMA_NEVT-1:0];
        end
        if (wr_acc && paddr == TMA_OFF_EVT)
        begin
            next_evt = evt_status & ~pwdata[TMA_NEVT-1:0];
        end
        next_evt = next_evt | evt_in; // set beats write-one clear
        // writing one to a flag is no effect; set wins over clear
        next_stat[TMA_LSB_FLAG +: 3] = (compare_a_status_reg[TMA_LSB_FLAG +: 3] & ~flag_clr)
                                     | flag_set;
        next_stat = next_stat | TMA_STAT_RSV;
    end

    // register state; standby holds initial values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            timer_mode_reg <= TMA_MODE_RESET;
            compare_a_status_reg <= TMA_STAT_RESET;
            evt_status <= TMA_EVT_ZERO;
            evt_mask <= TMA_EVT_ZERO;
            clr_armed <= 3'b000;
        end
        else if (standby)
        begin
            timer_mode_reg <= TMA_MODE_RESET;
            compare_a_status_reg <= TMA_STAT_RESET;
            evt_status <= TMA_EVT_ZERO;
            evt_mask <= TMA_EVT_ZERO;
            clr_armed <= 3'b000;
        end
        else
        begin
            timer_mode_reg <= next_mode;
            compare_a_status_reg <= next_stat;
            evt_status <= next_evt;
            evt_mask <= next_mask;
            clr_armed <= next_armed;
        end
    end

    // read data captured in the setup phase
    logic [31:0] next_prdata;
    always_comb
    begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite)
        begin
            case (paddr)
                TMA_OFF_MODE: next_prdata = {24'h00_0000, timer_mode_reg};
                TMA_OFF_STAT: next_prdata = {24'h00_0000, compare_a_status_reg};
                TMA_OFF_EVT: next_prdata = {28'h000_0000, evt_status};
                TMA_OFF_MASK: next_prdata = {28'h000_0000, evt_mask};
                default: next_prdata = TMA_WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= TMA_WORD_ZERO;
        end
        else
        begin
            prdata <= next_prdata;
        end
    end

    // pwm pins: set on compare-a, clear on compare-b
    logic [2:0] next_pin;
    always_comb
    begin
        next_pin = compare_a_pin;
        for (int i = 0; i < TMA_NCH; i++)
        begin
            if (!pulse_mode[i])
            begin
                next_pin[i] = 1'b0;
            end
            else if (chan_evt.match_b[i])
            begin
                next_pin[i] = 1'b0;
            end
            else if (chan_evt.match_a[i])
            begin
                next_pin[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_a_pin <= 3'b000;
        end
        else
        begin
            compare_a_pin <= next_pin;
        end
    end
    assign compare_a_pin_oe = pulse_mode;

    // channel 2 counting: quadrature in phase mode, else the normal tick
    logic qa_d;
    logic qb_d;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
    logic one_edge;
    tma_ch2_cnt_t next_cnt;
    assign a_rise = quadrature_in_a & ~qa_d;
    assign a_fall = ~quadrature_in_a & qa_d;
    assign b_rise = quadrature_in_b & ~qb_d;
    assign b_fall = ~quadrature_in_b & qb_d;
    // both pins moving together has no defined direction
    assign one_edge = (a_rise | a_fall) ^ (b_rise | b_fall);

    always_comb
    begin
        next_cnt.ovf_set = ch2_overflow | (ch2_underflow & ~overflow_direction_select);
        if (phase_count_select)
        begin
            next_cnt.count_en = one_edge;
            next_cnt.count_up = quad_up(a_rise, a_fall, b_rise, b_fall,
                                        quadrature_in_a, quadrature_in_b);
        end
        else
        begin
            next_cnt.count_en = ch2_clock_tick;
            next_cnt.count_up = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            qa_d <= 1'b0;
            qb_d <= 1'b0;
            ch2_cnt <= '0;
        end
        else
        begin
            qa_d <= quadrature_in_a;
            qb_d <= quadrature_in_b;
            ch2_cnt <= next_cnt;
        end
    end

    // checks
    a_mode_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        (timer_mode_reg & TMA_MODE_RSV) == TMA_MODE_RSV)
        else $error("mode reserved bits not one");
    a_stat_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        (compare_a_status_reg & TMA_STAT_RSV) == TMA_STAT_RSV)
        else $error("status reserved bits not one");
    a_standby_init: assert property (@(posedge pclk) disable iff (!presetn)
        standby |=> timer_mode_reg == TMA_MODE_RESET && compare_a_status_reg == TMA_STAT_RESET)
        else $error("standby did not initialise registers");
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_a_irq == (compare_a_status_reg[2:0] & compare_a_status_reg[6:4]))
        else $error("compare-a irq mismatch");
    a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
        (chan_evt.match_a[0] && !chan_evt.a_is_capture[0] && !standby)
        |=> compare_a_status_reg[0])
        else $error("flag 0 not set on match");
    a_capture_sets: assert property (@(posedge pclk) disable iff (!presetn)
        (chan_evt.capture_a[2] && chan_evt.a_is_capture[2] && !standby)
        |=> compare_a_status_reg[2])
        else $error("flag 2 not set on capture");
    a_one_no_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (compare_a_status_reg[1] && wr_acc && paddr == TMA_OFF_STAT && pwdata[1] && !standby)
        |=> compare_a_status_reg[1])
        else $error("writing one cleared a flag");
    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (flag_clr[1] && flag_set[1] && !standby) |=> compare_a_status_reg[1])
        else $error("set lost against clear");
    a_phase_tick: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_count_select && !one_edge && ch2_clock_tick) |=> !ch2_cnt.count_en)
        else $error("tick counted in phase mode");
    a_ovf_dir: assert property (@(posedge pclk) disable iff (!presetn)
        (overflow_direction_select && ch2_underflow && !ch2_overflow) |=> !ch2_cnt.ovf_set)
        else $error("underflow flagged with direction one");
    a_pwm_high: assert property (@(posedge pclk) disable iff (!presetn)
        (pulse_mode[1] && chan_evt.match_a[1] && !chan_evt.match_b[1] && !standby)
        |=> compare_a_pin[1] [*1])
        else $error("pwm pin not raised");

    // pwm pin checks
    a_pwm_low: assert property (@(posedge pclk) disable iff (!presetn)
        (pulse_mode[0] && chan_evt.match_b[0])
        |=> !compare_a_pin[0])
        else $error("pwm pin not lowered");
    a_pwm_off: assert property (@(posedge pclk) disable iff (!presetn)
        !pulse_mode[2]
        |=> !compare_a_pin[2])
        else $error("pin driven outside pwm mode");

    // phase and normal counting checks
    a_quad_a_up: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_count_select && a_rise && !b_rise && !b_fall && quadrature_in_b)
        |=> ch2_cnt.count_en && ch2_cnt.count_up)
        else $error("a rising with b high did not count up");
    a_quad_a_down: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_count_select && a_rise && !b_rise && !b_fall && !quadrature_in_b)
        |=> ch2_cnt.count_en && !ch2_cnt.count_up)
        else $error("a rising with b low did not count down");
    a_quad_b_down: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_count_select && b_rise && !a_rise && !a_fall && quadrature_in_a)
        |=> ch2_cnt.count_en && !ch2_cnt.count_up)
        else $error("b rising with a high did not count down");
    a_quad_b_up: assert property (@(posedge pclk) disable iff (!presetn)
        (phase_count_select && b_fall && !a_rise && !a_fall && quadrature_in_a)
        |=> ch2_cnt.count_en && ch2_cnt.count_up)
        else $error("b falling with a high did not count up");
    a_normal_tick: assert property (@(posedge pclk) disable iff (!presetn)
        (!phase_count_select && ch2_clock_tick)
        |=> ch2_cnt.count_en && ch2_cnt.count_up)
        else $error("normal tick not counted");

    // overflow select checks
    a_ovf_any: assert property (@(posedge pclk) disable iff (!presetn)
        (!overflow_direction_select && ch2_underflow)
        |=> ch2_cnt.ovf_set)
        else $error("underflow not flagged with direction zero");
    a_ovf_always: assert property (@(posedge pclk) disable iff (!presetn)
        ch2_overflow
        |=> ch2_cnt.ovf_set)
        else $error("overflow not flagged");

    // flag clear checks
    a_clear_needs_read: assert property (@(posedge pclk) disable iff (!presetn)
        (compare_a_status_reg[2] && !clr_armed[2] && wr_acc && paddr == TMA_OFF_STAT && !standby)
        |=> compare_a_status_reg[2])
        else $error("flag cleared without a prior read");
    a_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (clr_armed[2] && wr_acc && paddr == TMA_OFF_STAT && !pwdata[2] && !flag_set[2])
        |=> !compare_a_status_reg[2])
        else $error("armed flag not cleared by zero write");

    // register write checks
    a_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == TMA_OFF_MODE && !standby)
        |=> timer_mode_reg[TMA_LSB_PWM +: 3] == $past(pwdata[TMA_LSB_PWM +: 3]))
        else $error("pwm mode bits not written");
    a_enable_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_acc && paddr == TMA_OFF_STAT && !standby)
        |=> compare_a_status_reg[TMA_LSB_IEN +: 3] == $past(pwdata[TMA_LSB_IEN +: 3]))
        else $error("interrupt enable bits not written");
endmodule : tma_core

/* verification/tma_encoder.sv */
// Purpose: quadrature encoder model on the channel 2 phase pins
// Assumes: pins change just after a rising pclk edge
// Notes: gray steps, one pin moves per step; gap sets fast or slow turning
`timescale 1ns/1ns
module tma_encoder
(
    input wire logic pclk,
    output logic quadrature_in_a,
    output logic quadrature_in_b
);
    logic [1:0] phase = 2'b00;
    // phase order 00,01,11,10 on (a,b) is the up direction
    assign quadrature_in_a = phase[1];
    assign quadrature_in_b = phase[1] ^ phase[0];
    // one step, then gap idle cycles before the next may start
    task automatic step(input logic up, input int gap);
        @(posedge pclk);
        phase <= up ? phase + 2'b01 : phase - 2'b01;
        repeat (gap) @(posedge pclk);
    endtask : step
endmodule : tma_encoder

/* verification/tma_core_bench.sv */
// Purpose: self-checking bench for the timer mode / compare-a status block
// Assumes: zero-wait APB slave; events take effect one edge after sampling
// Notes: stimulus by non-blocking assignment right after rising edges
`timescale 1ns/1ns
module tma_core_bench;
    import tma_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic standby = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tma_chan_evt_t chan_evt = '0;
    logic [2:0] side = 3'b000;
    logic qa;
    logic qb;
    tma_ch2_cnt_t ch2_cnt;
    logic [2:0] pin;
    logic [2:0] pin_oe;
    logic [2:0] cirq;
    logic irq;
    logic [31:0] q;
    logic e;
    int errors = 0;
    int n_tests = 0;
    int n_up = 0;
    int n_dn = 0;
    // 20 MHz clock
    initial
    begin
        forever #25 pclk = ~pclk;
    end
    tma_core u_dut (
        .pclk(pclk), .presetn(presetn), .standby(standby),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_evt(chan_evt), .ch2_clock_tick(side[0]), .ch2_overflow(side[1]),
        .ch2_underflow(side[2]), .quadrature_in_a(qa), .quadrature_in_b(qb),
        .ch2_cnt(ch2_cnt), .compare_a_pin(pin), .compare_a_pin_oe(pin_oe),
        .cmp_a_irq(cirq), .irq(irq)
    );
    tma_encoder u_enc (.pclk(pclk), .quadrature_in_a(qa), .quadrature_in_b(qb));
    // tally channel 2 count pulses by direction
    always @(posedge pclk)
    begin
        if (ch2_cnt.count_en === 1'b1 && ch2_cnt.count_up === 1'b1)
            n_up++;
        if (ch2_cnt.count_en === 1'b1 && ch2_cnt.count_up === 1'b0)
            n_dn++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one APB transfer, released only after pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask : rd
    // one-cycle event and side pulses, then settle to the falling edge
    task automatic ev(input tma_chan_evt_t v, input logic [2:0] s);
        @(posedge pclk);
        chan_evt <= v;
        side <= s;
        @(posedge pclk);
        chan_evt <= '0;
        side <= 3'b000;
        @(negedge pclk);
    endtask : ev
    task automatic end_of_test();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    // hang guard, far beyond the sequence length
    initial
    begin
        repeat (3000) @(posedge pclk);
        errors++;
        end_of_test();
    end
    // main sequence
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(TMA_OFF_MODE, 32'h0000_0098);
        rd(TMA_OFF_STAT, 32'h0000_0088);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk({31'd0, e}, 32'h0000_0001);
        wr(TMA_OFF_MODE, 32'h0000_0000);
        rd(TMA_OFF_MODE, 32'h0000_0098);
        wr(TMA_OFF_MODE, 32'h0000_0067);
        rd(TMA_OFF_MODE, 32'h0000_00ff);
        chk(32'(pin_oe), 32'h0000_0007);
        wr(TMA_OFF_STAT, 32'h0000_00ff);
        rd(TMA_OFF_STAT, 32'h0000_00f8);
        ev(12'he00, 3'b000);
        chk(32'(cirq), 32'h0000_0007);
        chk(32'(pin), 32'h0000_0007);
        ev(12'h0c0, 3'b000);
        chk(32'(pin), 32'h0000_0004);
        rd(TMA_OFF_EVT, 32'h0000_0007);
        wr(TMA_OFF_MASK, 32'h0000_0001);
        @(negedge pclk);
        chk({31'd0, irq}, 32'h0000_0001);
        wr(TMA_OFF_MASK, 32'h0000_0000);
        @(negedge pclk);
        chk({31'd0, irq}, 32'h0000_0000);
        wr(TMA_OFF_EVT, 32'h0000_000f);
        rd(TMA_OFF_EVT, 32'h0000_0000);
        rd(TMA_OFF_STAT, 32'h0000_00ff);
        wr(TMA_OFF_STAT, 32'h0000_0070);
        rd(TMA_OFF_STAT, 32'h0000_00f8);
        chk(32'(cirq), 32'h0000_0000);
        ev(12'h036, 3'b000);
        wr(TMA_OFF_STAT, 32'h0000_0070);
        rd(TMA_OFF_STAT, 32'h0000_00fe);
        wr(TMA_OFF_STAT, 32'h0000_0076);
        rd(TMA_OFF_STAT, 32'h0000_00fe);
        // zero write to armed flags meets a channel 1 match at the write edge
        fork
            wr(TMA_OFF_STAT, 32'h0000_0070);
            begin
                repeat (2) @(posedge pclk);
                chan_evt <= 12'h400;
                @(posedge pclk);
                chan_evt <= '0;
            end
        join
        rd(TMA_OFF_STAT, 32'h0000_00fa);
        wr(TMA_OFF_STAT, 32'h0000_0070);
        rd(TMA_OFF_STAT, 32'h0000_00f8);
        // quadrature turning, fast then slow, plus an ignored tick
        repeat (4) u_enc.step(1'b1, 2);
        repeat (4) u_enc.step(1'b0, 5);
        ev(12'h000, 3'b001);
        repeat (2) @(posedge pclk);
        chk(32'(n_up), 32'h0000_0004);
        chk(32'(n_dn), 32'h0000_0004);
        // overflow-only, then overflow or underflow
        wr(TMA_OFF_EVT, 32'h0000_000f);
        ev(12'h000, 3'b100);
        rd(TMA_OFF_EVT, 32'h0000_0000);
        ev(12'h000, 3'b010);
        rd(TMA_OFF_EVT, 32'h0000_0008);
        wr(TMA_OFF_MODE, 32'h0000_0000);
        wr(TMA_OFF_EVT, 32'h0000_000f);
        ev(12'h000, 3'b100);
        rd(TMA_OFF_EVT, 32'h0000_0008);
        chk(32'(pin_oe), 32'h0000_0000);
        ev(12'h000, 3'b001);
        repeat (2) @(posedge pclk);
        chk(32'(n_up), 32'h0000_0005);
        // standby brings both registers back
        wr(TMA_OFF_MODE, 32'h0000_0060);
        @(posedge pclk);
        standby <= 1'b1;
        @(posedge pclk);
        standby <= 1'b0;
        rd(TMA_OFF_MODE, 32'h0000_0098);
        rd(TMA_OFF_STAT, 32'h0000_0088);
        end_of_test();
    end
endmodule : tma_core_bench
